// ===== dwc_write_decoder.sv
// Write command decoder for an octal 12-bit converter register bank
//
// Behaviour
// - Command 0: write one channel's input register
// - Value is upper byte plus upper nibble
// - Channel top bit set, not all ones: ignored
// - Command 0 broadcast: write all input registers
// - Command 1: copy input to output register
// - Command 1 broadcast: update all output registers
// - Command 3: write and update one channel
// - Command 3 broadcast: write, update all channels
// - Apply on acknowledge falling edge after lower byte
module dwc_write_decoder (
    input logic mclk,
    input logic rst,
    input logic frame_start,
    input logic byte_valid,
    input logic [7:0] byte_data,
    input logic ack_fall,
    output dwc_pkg::dwc_bank_t input_regs,
    output dwc_pkg::dwc_bank_t output_regs,
    output logic output_load_strobe
);

    dwc_pkg::dwc_regs_s r;
    dwc_pkg::dwc_regs_s next_r;
    dwc_pkg::dwc_mask_s masks;
    dwc_pkg::dwc_code_t value;
    logic apply;
    logic [3:0] cmd;
    logic [3:0] chan;

    // Action masks from the held command and access byte
    dwc_cmd_decode u_decode (
        .command_access_byte(r.cmd_byte),
        .masks(masks)
    );

    // Field views of the held bytes
    assign cmd = r.cmd_byte[dwc_pkg::CMD_MSB:dwc_pkg::CMD_LSB];
    assign chan = r.cmd_byte[dwc_pkg::CHAN_MSB:dwc_pkg::CHAN_LSB];
    assign value = {r.upper,
        r.lower[dwc_pkg::LOW_NIB_MSB:dwc_pkg::LOW_NIB_LSB]};

    // Commit point: acknowledge falling edge after the lower byte
    assign apply = !rst && !frame_start && (r.st == dwc_pkg::ST_LOWER)
        && ack_fall;

    // Next state of the whole decoder
    always_comb
    begin
        next_r = r;
        next_r.load = 1'b0;
        if (rst)
        begin
            next_r.st = dwc_pkg::ST_IDLE;
            next_r.cmd_byte = dwc_pkg::RESET_BYTE;
            next_r.upper = dwc_pkg::RESET_BYTE;
            next_r.lower = dwc_pkg::RESET_BYTE;
            next_r.in_regs = {dwc_pkg::NUM_CHAN{dwc_pkg::RESET_CODE}};
            next_r.out_regs = {dwc_pkg::NUM_CHAN{dwc_pkg::RESET_CODE}};
        end
        else if (frame_start)
        begin
            next_r.st = dwc_pkg::ST_IDLE;
        end
        else
        begin
            // Byte order: command, upper data, lower data
            case (r.st)
                dwc_pkg::ST_IDLE:
                begin
                    if (byte_valid)
                    begin
                        next_r.cmd_byte = byte_data;
                        next_r.st = dwc_pkg::ST_CMD;
                    end
                end
                dwc_pkg::ST_CMD:
                begin
                    if (byte_valid)
                    begin
                        next_r.upper = byte_data;
                        next_r.st = dwc_pkg::ST_UPPER;
                    end
                end
                dwc_pkg::ST_UPPER:
                begin
                    if (byte_valid)
                    begin
                        next_r.lower = byte_data;
                        next_r.st = dwc_pkg::ST_LOWER;
                    end
                end
                dwc_pkg::ST_LOWER:
                begin
                    if (ack_fall)
                    begin
                        next_r.st = dwc_pkg::ST_IDLE;
                    end
                end
                default:
                begin
                    next_r.st = dwc_pkg::ST_IDLE;
                end
            endcase
            // Register bank writes and transfers at the commit point
            for (int i = 0; i < dwc_pkg::NUM_CHAN; i++)
            begin
                if (apply && masks.wr[i])
                begin
                    next_r.in_regs[i] = value;
                end
                if (apply && masks.upd[i])
                begin
                    next_r.out_regs[i] = masks.wr[i] ? value
                        : r.in_regs[i];
                end
            end
            next_r.load = apply && (|masks.upd);
        end
    end

    // State register
    always_ff @(posedge mclk)
    begin
        r <= next_r;
    end

    // Outputs straight from flip-flops
    assign input_regs = r.in_regs;
    assign output_regs = r.out_regs;
    assign output_load_strobe = r.load;

    // Checks
    property p_write_one;
        @(posedge mclk) disable iff (rst)
        apply && cmd == dwc_pkg::CMD_WRITE_INPUT && !chan[3]
        |=> input_regs[$past(chan[2:0])] == $past(value)
            && output_regs == $past(output_regs);
    endproperty
    a_write_one: assert property (p_write_one)
        else $error("single input write lost");

    property p_nibble;
        @(posedge mclk) disable iff (rst)
        apply && cmd == dwc_pkg::CMD_WRITE_INPUT && !chan[3]
        |=> input_regs[$past(chan[2:0])][3:0] == $past(r.lower[7:4])
            && input_regs[$past(chan[2:0])][11:4] == $past(r.upper);
    endproperty
    a_nibble: assert property (p_nibble)
        else $error("data bytes packed wrongly");

    property p_invalid;
        @(posedge mclk) disable iff (rst)
        apply && chan[3] && chan != dwc_pkg::CHAN_BROADCAST
        |=> $stable(input_regs) && $stable(output_regs)
            && !output_load_strobe;
    endproperty
    a_invalid: assert property (p_invalid)
        else $error("invalid channel code acted on");

    property p_write_all;
        @(posedge mclk) disable iff (rst)
        apply && cmd == dwc_pkg::CMD_WRITE_INPUT
            && chan == dwc_pkg::CHAN_BROADCAST
        |=> input_regs == {8{$past(value)}} && $stable(output_regs);
    endproperty
    a_write_all: assert property (p_write_all)
        else $error("broadcast input write incomplete");

    property p_update_one;
        @(posedge mclk) disable iff (rst)
        apply && cmd == dwc_pkg::CMD_SELECT_UPDATE && !chan[3]
        |=> output_regs[$past(chan[2:0])] == $past(input_regs[chan[2:0]])
            && $stable(input_regs) && output_load_strobe;
    endproperty
    a_update_one: assert property (p_update_one)
        else $error("single update did not copy input");

    property p_update_all;
        @(posedge mclk) disable iff (rst)
        apply && cmd == dwc_pkg::CMD_SELECT_UPDATE
            && chan == dwc_pkg::CHAN_BROADCAST
        |=> output_regs == $past(input_regs) && $stable(input_regs);
    endproperty
    a_update_all: assert property (p_update_all)
        else $error("broadcast update incomplete");

    property p_write_update_one;
        @(posedge mclk) disable iff (rst)
        apply && cmd == dwc_pkg::CMD_WRITE_UPDATE && !chan[3]
        |=> input_regs[$past(chan[2:0])] == $past(value)
            && output_regs[$past(chan[2:0])] == $past(value);
    endproperty
    a_write_update_one: assert property (p_write_update_one)
        else $error("write and update of one channel failed");

    property p_write_update_all;
        @(posedge mclk) disable iff (rst)
        apply && cmd == dwc_pkg::CMD_WRITE_UPDATE
            && chan == dwc_pkg::CHAN_BROADCAST
        |=> input_regs == {8{$past(value)}}
            && output_regs == {8{$past(value)}};
    endproperty
    a_write_update_all: assert property (p_write_update_all)
        else $error("broadcast write and update incomplete");

    property p_commit_point;
        @(posedge mclk) disable iff (rst)
        !(r.st == dwc_pkg::ST_LOWER && ack_fall) || frame_start
        |=> $stable(input_regs) && $stable(output_regs);
    endproperty
    a_commit_point: assert property (p_commit_point)
        else $error("registers changed outside commit point");

    property p_order;
        @(posedge mclk) disable iff (rst)
        r.st == dwc_pkg::ST_IDLE && byte_valid && !frame_start
        |=> r.st == dwc_pkg::ST_CMD && r.cmd_byte == $past(byte_data);
    endproperty
    a_order: assert property (p_order)
        else $error("first byte not taken as command");

    property p_hold;
        @(posedge mclk) disable iff (rst)
        !$stable(output_regs) |-> $past(apply) && $past(|masks.upd)
            && output_load_strobe;
    endproperty
    a_hold: assert property (p_hold)
        else $error("output register changed without update");

endmodule

// ===== dwc_pkg.sv
// Constants, types and state layout of the write command decoder
package dwc_pkg;

    // Converter geometry
    localparam int NUM_CHAN = 8;
    localparam int CODE_W = 12;

    // Command and access byte field positions
    localparam int CMD_MSB = 7;
    localparam int CMD_LSB = 4;
    localparam int CHAN_MSB = 3;
    localparam int CHAN_LSB = 0;
    localparam int CHAN_TOP = 3;
    localparam int CHAN_IDX_MSB = 2;

    // Lower data byte: value nibble sits in the upper half
    localparam int LOW_NIB_MSB = 7;
    localparam int LOW_NIB_LSB = 4;

    // Command codes handled here
    localparam logic [3:0] CMD_WRITE_INPUT = 4'h0;
    localparam logic [3:0] CMD_SELECT_UPDATE = 4'h1;
    localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;

    // Channel field code for all channels at once
    localparam logic [3:0] CHAN_BROADCAST = 4'hF;

    // Power-on code of every register (zero scale)
    localparam logic [11:0] RESET_CODE = 12'h000;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] ALL_CHAN = 8'hFF;
    localparam logic [7:0] NO_CHAN = 8'h00;
    localparam logic [7:0] ONE_CHAN = 8'h01;

    typedef logic [CODE_W-1:0] dwc_code_t;
    typedef logic [NUM_CHAN-1:0][CODE_W-1:0] dwc_bank_t;

    // Frame sequencer, Gray coded along the byte order
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_CMD = 2'h1,
        ST_UPPER = 2'h3,
        ST_LOWER = 2'h2
    } dwc_state_e;

    // Per-channel actions decoded from the command and access byte
    typedef struct packed {
        logic [NUM_CHAN-1:0] wr;
        logic [NUM_CHAN-1:0] upd;
    } dwc_mask_s;

    // Whole state of the decoder
    typedef struct packed {
        dwc_state_e st;
        logic [7:0] cmd_byte;
        logic [7:0] upper;
        logic [7:0] lower;
        dwc_bank_t in_regs;
        dwc_bank_t out_regs;
        logic load;
    } dwc_regs_s;

endpackage

// ===== dwc_cmd_decode.sv
// Command and access byte decoder: per-channel write and update masks
module dwc_cmd_decode (
    input logic [7:0] command_access_byte,
    output dwc_pkg::dwc_mask_s masks
);

    // Channel field to channel mask; top bit set is invalid unless all ones
    function automatic logic [7:0] chan_sel(input logic [3:0] chan);
        logic [7:0] sel;
        sel = dwc_pkg::NO_CHAN;
        if (chan == dwc_pkg::CHAN_BROADCAST)
        begin
            sel = dwc_pkg::ALL_CHAN;
        end
        else if (!chan[dwc_pkg::CHAN_TOP])
        begin
            sel = dwc_pkg::ONE_CHAN << chan[dwc_pkg::CHAN_IDX_MSB:0];
        end
        return sel;
    endfunction

    logic [3:0] cmd;
    logic [7:0] sel;

    assign cmd = command_access_byte[dwc_pkg::CMD_MSB:dwc_pkg::CMD_LSB];
    assign sel = chan_sel(
        command_access_byte[dwc_pkg::CHAN_MSB:dwc_pkg::CHAN_LSB]);

    // Command to action masks; other commands do nothing here
    always_comb
    begin
        masks.wr = dwc_pkg::NO_CHAN;
        masks.upd = dwc_pkg::NO_CHAN;
        case (cmd)
            dwc_pkg::CMD_WRITE_INPUT:
            begin
                masks.wr = sel;
            end
            dwc_pkg::CMD_SELECT_UPDATE:
            begin
                masks.upd = sel;
            end
            dwc_pkg::CMD_WRITE_UPDATE:
            begin
                masks.wr = sel;
                masks.upd = sel;
            end
            default:
            begin
                masks.wr = dwc_pkg::NO_CHAN;
                masks.upd = dwc_pkg::NO_CHAN;
            end
        endcase
    end

endmodule

// ===== dwc_master.sv
// Behavioural serial front end that hands write bytes to the decoder
module dwc_master (
    input wire logic mclk,
    output logic frame_start,
    output logic byte_valid,
    output logic [7:0] byte_data,
    output logic ack_fall
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle bus at time zero
    initial
    begin
        frame_start = 1'b0;
        byte_valid = 1'b0;
        byte_data = 8'h00;
        ack_fall = 1'b0;
    end

    // One received byte, strobed for one cycle
    task automatic put(input logic [7:0] b);
        @(negedge mclk);
        byte_valid = 1'b1;
        byte_data = b;
    endtask

    // Command byte, then upper and lower data; abort sends no lower byte and ends with a restart
    task automatic send(input logic [7:0] cmd_byte, input logic [7:0] up,
                        input logic [7:0] lo, input bit abort);
        put(cmd_byte);
        put(up);
        if (abort)
        begin
            @(negedge mclk);
            byte_valid = 1'b0;
            byte_data = ~byte_data;
            frame_start = 1'b1;
            @(negedge mclk);
            frame_start = 1'b0;
        end
        else
        begin
            put(lo);
            @(negedge mclk);
            byte_valid = 1'b0;
            byte_data = ~byte_data;
            ack_fall = 1'b1;
            @(negedge mclk);
            ack_fall = 1'b0;
        end
    endtask
endmodule

// ===== dwc_write_decoder_test.sv
// Self-checking bench of the write command decoder
module dwc_write_decoder_test;
    timeunit 1ns;
    timeprecision 1ns;

    logic mclk;
    logic rst;
    logic frame_start;
    logic byte_valid;
    logic ack_fall;
    logic output_load_strobe;
    logic exp_strobe;
    logic [7:0] byte_data;
    logic [7:0] cmd_byte;
    dwc_pkg::dwc_bank_t input_regs;
    dwc_pkg::dwc_bank_t output_regs;
    dwc_pkg::dwc_bank_t exp_in;
    dwc_pkg::dwc_bank_t exp_out;
    int err_count;
    int n_compared;
    int cycles;
    int seed;
    logic [3:0] cmd_tab [6] = '{4'h0, 4'h1, 4'h3, 4'h2, 4'h4, 4'hF};
    logic [23:0] corner [10] = '{24'h32ABCD, 24'h0F5A3F, 24'h10FFFF,
        24'h1FFFFF, 24'h3F123F, 24'h08FFFF, 24'h19FFFF, 24'h3AFFFF,
        24'h2F777F, 24'h07FEDC};

    dwc_master m (
        .mclk(mclk),
        .frame_start(frame_start),
        .byte_valid(byte_valid),
        .byte_data(byte_data),
        .ack_fall(ack_fall)
    );

    dwc_write_decoder uut (
        .mclk(mclk),
        .rst(rst),
        .frame_start(frame_start),
        .byte_valid(byte_valid),
        .byte_data(byte_data),
        .ack_fall(ack_fall),
        .input_regs(input_regs),
        .output_regs(output_regs),
        .output_load_strobe(output_load_strobe)
    );

    // Clock, 50 ns period
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Compare and count
    task automatic chk(input logic [95:0] seen, input logic [95:0] want);
        n_compared++;
        if (seen !== want)
        begin
            err_count++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask

    // Verdict and end of run
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Expected register banks after one complete frame
    function automatic void model(input logic [7:0] c, input logic [7:0] up,
                                  input logic [7:0] lo);
        logic [11:0] v;
        logic ok;
        v = {up, lo[7:4]};
        ok = !c[3] || c[3:0] == 4'hF;
        exp_strobe = 1'b0;
        for (int k = 0; k < 8; k++)
            if (ok && (c[3:0] == 4'hF || c[2:0] == k[2:0]))
            begin
                if (c[7:4] == 4'h0 || c[7:4] == 4'h3)
                    exp_in[k] = v;
                if (c[7:4] == 4'h1 || c[7:4] == 4'h3)
                begin
                    exp_out[k] = exp_in[k];
                    exp_strobe = 1'b1;
                end
            end
    endfunction

    // One frame through the master and its checks
    task automatic frame(input logic [7:0] c, input logic [7:0] up,
                         input logic [7:0] lo, input bit abort);
        m.send(c, up, lo, abort);
        if (!abort)
            model(c, up, lo);
        else
            exp_strobe = 1'b0;
        chk(input_regs, exp_in);
        chk(output_regs, exp_out);
        chk({95'h0, output_load_strobe}, {95'h0, exp_strobe});
        @(negedge mclk);
        chk({95'h0, output_load_strobe}, 96'h0);
    endtask

    // Cycle ceiling against hangs
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            print_verdict();
        end
    end

    // Main sequence
    initial
    begin
        rst = 1'b1;
        err_count = 0;
        n_compared = 0;
        cycles = 0;
        seed = 74609;
        exp_in = '0;
        exp_out = '0;
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        chk(input_regs, exp_in);
        chk(output_regs, exp_out);
        foreach (corner[j])
            frame(corner[j][23:16], corner[j][15:8], corner[j][7:0], 1'b0);
        frame(8'h34, 8'hEE, 8'hEE, 1'b1);
        // Reset in mid-run clears both banks
        @(negedge mclk);
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        exp_in = '0;
        exp_out = '0;
        chk(input_regs, exp_in);
        chk(output_regs, exp_out);
        for (int n = 0; n < 300; n++)
        begin
            cmd_byte = {cmd_tab[{$random(seed)} % 6], 4'($random(seed))};
            frame(cmd_byte, 8'($random(seed)), 8'($random(seed)), n % 37 == 5);
        end
        print_verdict();
    end
endmodule
